// ===== inc/usb_sie_pkg.sv
/*
 * shared constants of the serial engine status, endpoint and descriptor block.
 * assumes one 200 MHz clock and a 32-bit classic wishbone register port.
 */
// Behaviour
// - status window holds the finished entry from the same edge on which the done flag rises
// - finished-transaction status queues in a four-entry fifo behind the window
// - each entry gives endpoint number, direction and ping-pong pointer
// - clearing done flag pops fifo; flag returns within six instruction cycles if more
// - endpoint request while fifo is full gets a NAK automatically
// - each endpoint pair has an identical control register with handshake enable; the code has eight, endpoints 8 to 15 share those of 0 to 7
// - setup accepted only while the control-disable bit is clear
// - out needs out-enable, in needs in-enable
// - issued stall sets the pair's stall flag until firmware or reset clears it
// - device address clears on bus reset or device reset
// - only tokens addressed to the device address get a response
// - frame number is 11 bits split low eight and high three
// - frame number loads on each start-of-frame token received while not suspended and is read-only
// - frame number is only meaningful while not suspended
// - descriptor is four bytes: status, count, address low, address high
// - descriptor n status byte sits at linear 2000h plus 4n minus 1
// - descriptor bytes act as descriptors only while in-enable is set
// - descriptor bytes are not initialised by any reset
// - all but eight bytes of bank zero may serve as buffer space
// - engine clears owner flag when the descriptor's transaction completes on an endpoint with in-enable set
package usb_sie_pkg;
    localparam int CLK_PS = 5000;
    localparam int INSTR_CYCLE_PS = 83333;
    localparam int REARM_LIMIT_TCY = 6;
    localparam int REARM_LIMIT_CYC = REARM_LIMIT_TCY * INSTR_CYCLE_PS / CLK_PS;
    localparam logic [6:0] REARM_CYC = 7'h02;
    localparam int STAT_DEPTH = 4;
    localparam int NUM_EP = 8;
    localparam int RAM_BYTES = 512;
    localparam int RAM_RESERVED = 8;
    // register byte offsets
    localparam logic [15:0] OFS_STATUS_WIN = 16'h0000;
    localparam logic [15:0] OFS_DONE_FLAG = 16'h0004;
    localparam logic [15:0] OFS_DEV_ADDR = 16'h0008;
    localparam logic [15:0] OFS_FRAME_LO = 16'h000c;
    localparam logic [15:0] OFS_FRAME_HI = 16'h0010;
    localparam logic [15:0] OFS_EP_CTL = 16'h0020;
    localparam logic [15:0] OFS_RAM = 16'h1000;
    localparam logic [7:0] DEV_ADDR_RST = 8'h00;
    // linear base of the descriptor table
    localparam logic [15:0] BDT_LINEAR_BASE = 16'h2000;
    localparam logic [1:0] BD_OFS_STAT = 2'h0;
    localparam logic [1:0] BD_OFS_CNT = 2'h1;
    localparam logic [1:0] BD_OFS_ADRL = 2'h2;
    localparam logic [1:0] BD_OFS_ADRH = 2'h3;
    localparam int BD_OWNER_BIT = 7;
    // endpoint control fields
    localparam int EP_STALL_BIT = 0;
    localparam int EP_IN_EN_BIT = 1;
    localparam int EP_OUT_EN_BIT = 2;
    localparam int EP_CONDIS_BIT = 3;
    localparam int EP_HSHK_BIT = 4;
    // status entry fields
    localparam int ST_PPBI_BIT = 1;
    localparam int ST_DIR_BIT = 2;
    localparam int ST_EP_LSB = 3;
    typedef enum logic [1:0] {
        PID_SETUP = 2'h0,
        PID_OUT = 2'h1,
        PID_IN = 2'h2,
        PID_SOF = 2'h3
    } tok_pid_t;
    typedef enum logic [1:0] {
        RSP_ACCEPT = 2'h0,
        RSP_NAK = 2'h1,
        RSP_IGNORE = 2'h2
    } tok_rsp_t;
endpackage

// ===== inc/stat_fifo_if.sv
/*
 * carrier between the block core and its transaction status fifo.
 * assumes both ends on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface stat_fifo_if;
    logic push;
    logic [7:0] push_data;
    logic pop;
    logic [7:0] head;
    logic empty;
    logic full;
    modport core (output push, output push_data, output pop,
                  input head, input empty, input full);
    modport fifo (input push, input push_data, input pop,
                  output head, output empty, output full);
endinterface
`default_nettype wire

// ===== hw/stat_fifo.sv
/*
 * small first-in first-out store for transaction status bytes.
 * assumes the core never pushes while full; a push then is dropped.
 */
`timescale 1ns/1ps
`default_nettype none
module stat_fifo
    import usb_sie_pkg::*;
#(
    parameter int DEPTH = STAT_DEPTH
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    stat_fifo_if.fifo f
);
    localparam int AW = $clog2(DEPTH);
    logic [7:0] mem [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] cnt_r;
    wire do_push = f.push && !f.full;
    wire do_pop = f.pop && !f.empty;

    assign f.head = mem[rd_r];
    assign f.empty = (cnt_r == '0);
    assign f.full = (cnt_r == (AW+1)'(DEPTH));

    // storage has no reset; the count decides what is valid
    always_ff @(posedge i_ref_clk) begin
        if (do_push) begin
            mem[wr_r] <= f.push_data;
        end
    end

    // each pointer advances on its own push or pop so entries leave in arrival order
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end else begin
            wr_r <= do_push ? AW'(wr_r + 1'b1) : wr_r;
            rd_r <= do_pop ? AW'(rd_r + 1'b1) : rd_r;
            cnt_r <= (AW+1)'(cnt_r + do_push - do_pop);
        end
    end
endmodule
`default_nettype wire

// ===== hw/usb_sie_status.sv
/*
 * status window, endpoint control, device address, frame number and
 * descriptor ram of a usb device serial engine, with a wishbone slave.
 * assumes the packet engine beside it runs on i_ref_clk and gives
 * one-cycle pulses for tokens, completions and stalls.
 */
`timescale 1ns/1ps
`default_nettype none
module usb_sie_status
    import usb_sie_pkg::*;
#(
    parameter int EPS = NUM_EP,
    parameter int RAM_N = RAM_BYTES
) (
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [15:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire logic i_tok_valid,
    input wire logic [1:0] i_tok_pid,
    input wire logic [6:0] i_tok_addr,
    input wire logic [3:0] i_tok_ep,
    input wire logic [10:0] i_tok_frame,
    output logic o_rsp_valid,
    output logic [1:0] o_rsp_code,
    output logic o_rsp_hshk,
    input wire logic i_xact_done,
    input wire logic [3:0] i_xact_ep,
    input wire logic i_xact_dir,
    input wire logic i_xact_ppbi,
    input wire logic [5:0] i_xact_bd,
    input wire logic i_stall_issued,
    input wire logic [3:0] i_stall_ep,
    input wire logic i_bus_reset,
    input wire logic i_suspend,
    input wire logic [5:0] i_bd_sel,
    input wire logic [3:0] i_bd_ep,
    output logic [31:0] o_bd_word,
    output logic o_bd_valid,
    output logic o_done_flag
);
    localparam int RAW = $clog2(RAM_N);

    typedef enum logic [1:0] {
        WB_IDLE = 2'b01,
        WB_ACK = 2'b10
    } wb_state_t;

    ////////////////////////////////////////////////////////////////////////
    // functions

    // ram index of byte k of descriptor n
    function automatic logic [RAW-1:0] bd_idx(input logic [5:0] n, input logic [1:0] k);
        logic [15:0] lin;
        lin = 16'(BDT_LINEAR_BASE + {8'h00, n, 2'b00} - 16'h0001 + {14'h0000, k});
        return RAW'(lin - BDT_LINEAR_BASE);
    endfunction

    // endpoint number to control register slot
    function automatic logic [2:0] ep_slot(input logic [3:0] ep);
        return ep[2:0];
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // state

    wb_state_t wb_state_r;
    wb_state_t wb_state_nxt;
    logic [7:0] ep_ctl_r [EPS];
    logic [7:0] dev_addr_r;
    logic [10:0] frame_r;
    logic [7:0] window_r;
    logic done_r;
    logic [6:0] rearm_r;
    logic [7:0] ram [RAM_N];
    logic [31:0] rd_nxt;

    stat_fifo_if sf ();

    stat_fifo #(
        .DEPTH(STAT_DEPTH)
    ) u_fifo (
        .i_ref_clk(i_ref_clk),
        .i_rst_n(i_rst_n),
        .f(sf)
    );

    ////////////////////////////////////////////////////////////////////////
    // bus decode

    wire req = i_wb_cyc && i_wb_stb;
    // a write lands on the edge where the master sees ack
    wire wr_go = req && i_wb_we && i_wb_sel[0] && wb_state_r == WB_ACK;
    wire hit_done = i_wb_adr == OFS_DONE_FLAG;
    wire hit_addr = i_wb_adr == OFS_DEV_ADDR;
    wire hit_ep = i_wb_adr[15:5] == OFS_EP_CTL[15:5] && i_wb_adr[1:0] == 2'b00;
    wire [2:0] wb_ep = i_wb_adr[4:2];
    wire [15:0] ram_ofs = 16'(i_wb_adr - OFS_RAM);
    wire hit_ram = i_wb_adr >= OFS_RAM && ram_ofs < 16'(RAM_N * 4)
        && i_wb_adr[1:0] == 2'b00;
    wire [RAW-1:0] ram_wb_idx = RAW'(ram_ofs[15:2]);

    // bus handshake: one wait state, then ack for one cycle
    assign wb_state_nxt = (wb_state_r == WB_IDLE && req) ? WB_ACK : WB_IDLE;

    // read mux; unmapped words read as zero
    always_comb begin
        rd_nxt = 32'h0000_0000;
        if (i_wb_adr == OFS_STATUS_WIN) begin
            rd_nxt[7:0] = window_r;
        end else if (hit_done) begin
            rd_nxt[0] = done_r;
        end else if (hit_addr) begin
            rd_nxt[7:0] = dev_addr_r;
        end else if (i_wb_adr == OFS_FRAME_LO) begin
            rd_nxt[7:0] = frame_r[7:0];
        end else if (i_wb_adr == OFS_FRAME_HI) begin
            rd_nxt[2:0] = frame_r[10:8];
        end else if (hit_ep) begin
            rd_nxt[7:0] = ep_ctl_r[wb_ep];
        end else if (hit_ram) begin
            rd_nxt[7:0] = ram[ram_wb_idx];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            wb_state_r <= WB_IDLE;
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0000_0000;
        end else begin
            wb_state_r <= wb_state_nxt;
            o_wb_ack <= wb_state_nxt == WB_ACK;
            o_wb_dat <= rd_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // status fifo and done flag

    // firmware clears the flag by writing zero to bit 0
    wire done_clr = wr_go && hit_done && !i_wb_dat[0] && done_r;
    wire [7:0] entry = {1'b0, i_xact_ep, i_xact_dir, i_xact_ppbi, 1'b0};

    assign sf.push = i_xact_done;
    assign sf.push_data = entry;
    assign sf.pop = done_clr;

    // the flag comes back a short guard after a pop so the window settles;
    // REARM_CYC must stay far below REARM_LIMIT_CYC
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            done_r <= 1'b0;
            rearm_r <= 7'h00;
            window_r <= 8'h00;
        end else if (done_clr) begin
            done_r <= 1'b0;
            rearm_r <= REARM_CYC;
        end else if (rearm_r != 7'h00) begin
            rearm_r <= 7'(rearm_r - 7'h01);
        end else if (!done_r && !sf.empty) begin
            done_r <= 1'b1;
            window_r <= sf.head;
        end
    end

    assign o_done_flag = done_r;

    ////////////////////////////////////////////////////////////////////////
    // endpoint control registers

    generate
        for (genvar e = 0; e < EPS; e++) begin : g_ep
            wire fw_wr = wr_go && hit_ep && wb_ep == 3'(e);
            wire st_set = i_stall_issued && ep_slot(i_stall_ep) == 3'(e);
            always_ff @(posedge i_ref_clk) begin
                if (!i_rst_n) begin
                    ep_ctl_r[e] <= 8'h00;
                end else begin
                    if (fw_wr) begin
                        // firmware may only clear the stall flag
                        ep_ctl_r[e] <= {i_wb_dat[7:1],
                                        i_wb_dat[EP_STALL_BIT] & ep_ctl_r[e][EP_STALL_BIT]};
                    end
                    if (st_set) begin
                        ep_ctl_r[e][EP_STALL_BIT] <= 1'b1;
                    end
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // device address and frame number

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || i_bus_reset) begin
            dev_addr_r <= DEV_ADDR_RST;
        end else if (wr_go && hit_addr) begin
            dev_addr_r <= i_wb_dat[7:0];
        end
    end

    // held while suspended, since the engine clock is stopped then
    wire sof_load = i_tok_valid && i_tok_pid == PID_SOF && !i_suspend;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            frame_r <= 11'h000;
        end else if (sof_load) begin
            frame_r <= i_tok_frame;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // token screening

    wire [7:0] tok_ctl = ep_ctl_r[ep_slot(i_tok_ep)];
    wire addr_ok = {1'b0, i_tok_addr} == dev_addr_r;
    wire dir_ok = (i_tok_pid == PID_SETUP && !tok_ctl[EP_CONDIS_BIT])
        || (i_tok_pid == PID_OUT && tok_ctl[EP_OUT_EN_BIT])
        || (i_tok_pid == PID_IN && tok_ctl[EP_IN_EN_BIT]);
    wire [1:0] rsp_nxt = !(addr_ok && dir_ok) ? RSP_IGNORE
        : sf.full ? RSP_NAK : RSP_ACCEPT;

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_rsp_valid <= 1'b0;
            o_rsp_code <= RSP_IGNORE;
            o_rsp_hshk <= 1'b0;
        end else begin
            o_rsp_valid <= i_tok_valid && i_tok_pid != PID_SOF;
            o_rsp_code <= rsp_nxt;
            o_rsp_hshk <= tok_ctl[EP_HSHK_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // descriptor ram

    // completion hands the descriptor back only on an enabled endpoint
    wire own_clr = i_xact_done && ep_ctl_r[ep_slot(i_xact_ep)][EP_IN_EN_BIT];
    wire [RAW-1:0] own_idx = bd_idx(i_xact_bd, BD_OFS_STAT);

    // no reset: contents are undefined after any reset; firmware owns
    // sharing discipline since nothing blocks access to engine buffers
    always_ff @(posedge i_ref_clk) begin
        if (wr_go && hit_ram) begin
            ram[ram_wb_idx] <= i_wb_dat[7:0];
        end
        if (own_clr) begin
            ram[own_idx][BD_OWNER_BIT] <= 1'b0;
        end
    end

    // engine view of one descriptor, status byte lowest
    wire bd_en = ep_ctl_r[ep_slot(i_bd_ep)][EP_IN_EN_BIT];

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            o_bd_word <= 32'h0000_0000;
            o_bd_valid <= 1'b0;
        end else begin
            o_bd_word <= {ram[bd_idx(i_bd_sel, BD_OFS_ADRH)],
                          ram[bd_idx(i_bd_sel, BD_OFS_ADRL)],
                          ram[bd_idx(i_bd_sel, BD_OFS_CNT)],
                          ram[bd_idx(i_bd_sel, BD_OFS_STAT)]};
            o_bd_valid <= bd_en;
        end
    end
endmodule
`default_nettype wire

// ===== testbench/usb_sie_checker.sv
/*
 * port-level assertions for the serial engine status block.
 * assumes it is bound to usb_sie_status and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none
module usb_sie_checker
    import usb_sie_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_rst_n,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [15:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    input wire logic o_wb_ack,
    input wire logic i_tok_valid,
    input wire logic [1:0] i_tok_pid,
    input wire logic [6:0] i_tok_addr,
    input wire logic o_rsp_valid,
    input wire logic [1:0] o_rsp_code,
    input wire logic i_xact_done,
    input wire logic i_bus_reset,
    input wire logic o_done_flag
);
    logic [7:0] addr_r;
    logic [2:0] cnt_r;
    wire logic bus_wr;
    wire logic clr_w;
    wire logic tok_w;
    // a write lands only at the edge that sees ack
    assign bus_wr = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack && i_wb_sel[0];
    assign clr_w = bus_wr && i_wb_adr == OFS_DONE_FLAG && !i_wb_dat[0] && o_done_flag;
    assign tok_w = i_tok_valid && i_tok_pid != PID_SOF;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);
    ////////////////////////////////////////////////////////////////////////////////
    // shadow address, cleared by bus reset as well
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n || i_bus_reset) begin
            addr_r <= 8'h00;
        end else if (bus_wr && i_wb_adr == OFS_DEV_ADDR) begin
            addr_r <= i_wb_dat[7:0];
        end
    end
    // shadow fifo fill; pushes when full are dropped
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_n) begin
            cnt_r <= 3'h0;
        end else begin
            cnt_r <= cnt_r + 3'(i_xact_done && cnt_r < 3'h4) - 3'(clr_w);
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    a_ack_pulse: assert property (o_wb_ack |=> !o_wb_ack)
        else $error("ack longer than one cycle");
    a_ack_answer: assert property (i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("bus request not answered");
    a_rsp_answer: assert property (tok_w |=> o_rsp_valid)
        else $error("token without response");
    a_rsp_cause: assert property (o_rsp_valid |-> $past(tok_w))
        else $error("response without token");
    a_addr_match: assert property (o_rsp_valid && o_rsp_code != RSP_IGNORE |->
        {1'b0, $past(i_tok_addr)} == $past(addr_r))
        else $error("answered foreign address");
    a_nak_full: assert property (o_rsp_valid && o_rsp_code != RSP_IGNORE |->
        (o_rsp_code == RSP_NAK) == ($past(cnt_r) == 3'h4))
        else $error("nak does not follow fifo fill");
    a_done_rise: assert property (i_xact_done && !o_done_flag && cnt_r == 3'h0 |->
        ##[1:4] o_done_flag)
        else $error("done flag late");
    a_clear_falls: assert property (clr_w |=> !o_done_flag)
        else $error("done flag kept after clear");
    a_rearm_more: assert property (clr_w && cnt_r > 3'h1 |=>
        !o_done_flag ##[1:4] o_done_flag)
        else $error("done flag not rearmed");
    a_empty_clear: assert property (clr_w && cnt_r == 3'h1 && !i_xact_done |=>
        !o_done_flag [*2])
        else $error("done flag set with empty fifo");
endmodule
`default_nettype wire

// ===== testbench/usb_host_model.sv
/*
 * host side model: sends tokens and collects the handshake answer.
 * assumes tasks are called from the bench at a rising edge.
 */
`timescale 1ns/1ps
`default_nettype none
module usb_host_model
    import usb_sie_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rsp_valid,
    input wire logic [1:0] i_rsp_code,
    input wire logic i_rsp_hshk,
    output logic o_tok_valid,
    output logic [1:0] o_tok_pid,
    output logic [6:0] o_tok_addr,
    output logic [3:0] o_tok_ep,
    output logic [10:0] o_tok_frame
);
    // idle lines carry junk, never a stale token
    initial begin
        o_tok_valid = 1'h0;
        o_tok_pid = 2'h3;
        o_tok_addr = 7'h55;
        o_tok_ep = 4'ha;
        o_tok_frame = 11'h2aa;
    end
    // one token, answer sampled in the cycle after it stands
    task automatic send(input logic [1:0] p, input logic [6:0] a, input logic [3:0] e,
                        input logic [10:0] f, output logic v, output logic [1:0] c,
                        output logic h);
        @(posedge i_clk);
        o_tok_valid <= 1'h1;
        o_tok_pid <= p;
        o_tok_addr <= a;
        o_tok_ep <= e;
        o_tok_frame <= f;
        @(posedge i_clk);
        o_tok_valid <= 1'h0;
        o_tok_addr <= ~a;
        o_tok_ep <= ~e;
        o_tok_frame <= ~f;
        @(posedge i_clk);
        v = i_rsp_valid;
        c = i_rsp_code;
        h = i_rsp_hshk;
    endtask
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
/*
 * self-checking bench for the serial engine status block.
 * assumes the checker and host model files are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top
    import usb_sie_pkg::*;
;
    logic i_ref_clk = '0, i_rst_n = '0, i_wb_cyc = '0, i_wb_stb = '0, i_wb_we = '0;
    logic i_xact_done = '0, i_xact_dir = '0, i_xact_ppbi = '0, i_stall_issued = '0;
    logic i_bus_reset = '0, i_suspend = '0, o_wb_ack, o_rsp_valid, o_rsp_hshk;
    logic o_bd_valid, o_done_flag, i_tok_valid;
    logic [15:0] i_wb_adr = '0;
    logic [31:0] i_wb_dat = '0, o_wb_dat, o_bd_word;
    logic [3:0] i_wb_sel = 4'hf, i_xact_ep = '0, i_stall_ep = '0, i_bd_ep = '0, i_tok_ep;
    logic [5:0] i_xact_bd = '0, i_bd_sel = '0;
    logic [1:0] o_rsp_code, i_tok_pid;
    logic [6:0] i_tok_addr;
    logic [10:0] i_tok_frame;
    int err_total = 0;
    int compares = 0;
    usb_sie_status dut_u (.i_ref_clk, .i_rst_n, .i_wb_cyc, .i_wb_stb, .i_wb_we, .i_wb_adr,
        .i_wb_dat, .i_wb_sel, .o_wb_dat, .o_wb_ack, .i_tok_valid, .i_tok_pid, .i_tok_addr,
        .i_tok_ep, .i_tok_frame, .o_rsp_valid, .o_rsp_code, .o_rsp_hshk, .i_xact_done,
        .i_xact_ep, .i_xact_dir, .i_xact_ppbi, .i_xact_bd, .i_stall_issued, .i_stall_ep,
        .i_bus_reset, .i_suspend, .i_bd_sel, .i_bd_ep, .o_bd_word, .o_bd_valid, .o_done_flag);
    usb_host_model host_u (.i_clk(i_ref_clk), .i_rsp_valid(o_rsp_valid),
        .i_rsp_code(o_rsp_code), .i_rsp_hshk(o_rsp_hshk), .o_tok_valid(i_tok_valid),
        .o_tok_pid(i_tok_pid), .o_tok_addr(i_tok_addr), .o_tok_ep(i_tok_ep),
        .o_tok_frame(i_tok_frame));
    // 200 MHz
    always #2.5 i_ref_clk = ~i_ref_clk;
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    // classic single cycle, held until ack is sampled
    task automatic wb(input logic w, input logic [15:0] a, input logic [31:0] d,
                      output logic [31:0] q);
        @(posedge i_ref_clk);
        i_wb_cyc <= 1'h1;
        i_wb_stb <= 1'h1;
        i_wb_we <= w;
        i_wb_adr <= a;
        i_wb_dat <= d;
        do @(posedge i_ref_clk); while (o_wb_ack !== 1'h1);
        q = o_wb_dat;
        i_wb_cyc <= 1'h0;
        i_wb_stb <= 1'h0;
    endtask
    task automatic rd(input logic [15:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'h0, a, 32'h0, q);
        chk($sformatf("read %h", a), q, e);
    endtask
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'h1, a, d, q);
    endtask
    task automatic tk(input logic [1:0] p, input logic [6:0] a, input logic [3:0] e,
                      input logic [1:0] x, input logic hx);
        logic v;
        logic [1:0] c;
        logic h;
        host_u.send(p, a, e, 11'h000, v, c, h);
        chk("rsp valid", 32'(v), 32'h1);
        chk("rsp code", 32'(c), 32'(x));
        chk("rsp hshk", 32'(h), 32'(hx));
    endtask
    // back-to-back completions, entry i on endpoint e+i
    task automatic push(input logic [3:0] e, input logic [5:0] b, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge i_ref_clk);
            i_xact_done <= 1'h1;
            i_xact_ep <= e + 4'(i);
            i_xact_dir <= i[0];
            i_xact_ppbi <= i[1];
            i_xact_bd <= b;
        end
        @(posedge i_ref_clk);
        i_xact_done <= 1'h0;
    endtask
    // skip the edge that launched a clear, else the old flag value is seen
    task automatic wflag;
        @(posedge i_ref_clk);
        for (int n = 0; n < 30 && o_done_flag !== 1'h1; n++) @(posedge i_ref_clk);
        chk("done flag", 32'(o_done_flag), 32'h1);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        rd(OFS_DEV_ADDR, 32'h0);
        rd(OFS_STATUS_WIN, 32'h0);
        rd(OFS_DONE_FLAG, 32'h0);
        rd(16'h0040, 32'h0);
        for (int e = 0; e < 8; e++) rd(OFS_EP_CTL + 16'(4 * e), 32'h0);
        wr(OFS_DEV_ADDR, 32'h2a);
        rd(OFS_DEV_ADDR, 32'h2a);
        @(posedge i_ref_clk);
        i_bus_reset <= 1'h1;
        @(posedge i_ref_clk);
        i_bus_reset <= 1'h0;
        rd(OFS_DEV_ADDR, 32'h0);
        wr(OFS_DEV_ADDR, 32'h2a);
        $display("test regs finished");
    endtask
    task automatic t_frame;
        logic v;
        logic [1:0] c;
        logic h;
        host_u.send(PID_SOF, 7'h2a, 4'h0, 11'h5a3, v, c, h);
        chk("sof quiet", 32'(v), 32'h0);
        rd(OFS_FRAME_LO, 32'ha3);
        rd(OFS_FRAME_HI, 32'h05);
        wr(OFS_FRAME_LO, 32'h11);
        rd(OFS_FRAME_LO, 32'ha3);
        i_suspend <= 1'h1;
        host_u.send(PID_SOF, 7'h2a, 4'h0, 11'h123, v, c, h);
        rd(OFS_FRAME_LO, 32'ha3);
        i_suspend <= 1'h0;
        $display("test frame finished");
    endtask
    task automatic t_tok;
        wr(OFS_EP_CTL + 16'h4, 32'h16);
        tk(PID_OUT, 7'h2b, 4'h1, RSP_IGNORE, 1'h1);
        tk(PID_OUT, 7'h2a, 4'h1, RSP_ACCEPT, 1'h1);
        tk(PID_IN, 7'h2a, 4'h1, RSP_ACCEPT, 1'h1);
        tk(PID_SETUP, 7'h2a, 4'h1, RSP_ACCEPT, 1'h1);
        tk(PID_OUT, 7'h2a, 4'h2, RSP_IGNORE, 1'h0);
        wr(OFS_EP_CTL + 16'h4, 32'h0a);
        tk(PID_SETUP, 7'h2a, 4'h1, RSP_IGNORE, 1'h0);
        tk(PID_OUT, 7'h2a, 4'h1, RSP_IGNORE, 1'h0);
        tk(PID_IN, 7'h2a, 4'h1, RSP_ACCEPT, 1'h0);
        rd(OFS_EP_CTL + 16'h4, 32'h0a);
        $display("test tokens finished");
    endtask
    task automatic t_fifo;
        push(4'h4, 6'h00, 4);
        wflag();
        repeat (2) @(posedge i_ref_clk);
        tk(PID_IN, 7'h2a, 4'h1, RSP_NAK, 1'h0);
        for (int i = 0; i < 4; i++) begin
            rd(OFS_STATUS_WIN, 32'({4'(4 + i), i[0], i[1], 1'b0}));
            wr(OFS_DONE_FLAG, 32'h0);
            if (i < 3) wflag();
        end
        repeat (8) @(posedge i_ref_clk);
        chk("done idle", 32'(o_done_flag), 32'h0);
        tk(PID_IN, 7'h2a, 4'h1, RSP_ACCEPT, 1'h0);
        $display("test fifo finished");
    endtask
    task automatic t_stall;
        @(posedge i_ref_clk);
        i_stall_issued <= 1'h1;
        i_stall_ep <= 4'h2;
        @(posedge i_ref_clk);
        i_stall_issued <= 1'h0;
        rd(OFS_EP_CTL + 16'h8, 32'h01);
        wr(OFS_EP_CTL + 16'h8, 32'h01);
        rd(OFS_EP_CTL + 16'h8, 32'h01);
        wr(OFS_EP_CTL + 16'h8, 32'h00);
        rd(OFS_EP_CTL + 16'h8, 32'h00);
        $display("test stall finished");
    endtask
    // descriptor 1 sits at ram bytes 3..6
    task automatic t_bd;
        logic [31:0] w = 32'h0100_4088;
        for (int k = 0; k < 4; k++) wr(OFS_RAM + 16'(4 * (3 + k)), 32'(w[8 * k +: 8]));
        @(posedge i_ref_clk);
        i_bd_sel <= 6'h01;
        i_bd_ep <= 4'h1;
        repeat (2) @(posedge i_ref_clk);
        chk("bd word", o_bd_word, w);
        chk("bd valid", 32'(o_bd_valid), 32'h1);
        i_bd_ep <= 4'h3;
        repeat (2) @(posedge i_ref_clk);
        chk("bd plain", 32'(o_bd_valid), 32'h0);
        rd(OFS_RAM + 16'hc, 32'h88);
        push(4'h1, 6'h01, 1);
        wflag();
        rd(OFS_RAM + 16'hc, 32'h08);
        wr(OFS_DONE_FLAG, 32'h0);
        $display("test descriptor finished");
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test;
        $display("checks %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge i_ref_clk);
        i_rst_n <= 1'h1;
        t_regs();
        t_frame();
        t_tok();
        t_fifo();
        t_stall();
        t_bd();
        finish_test();
    end
    // the whole run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge i_ref_clk);
        err_total++;
        finish_test();
    end
endmodule
bind usb_sie_status usb_sie_checker chk_u (.i_ref_clk, .i_rst_n, .i_wb_cyc, .i_wb_stb,
    .i_wb_we, .i_wb_adr, .i_wb_dat, .i_wb_sel, .o_wb_ack, .i_tok_valid, .i_tok_pid,
    .i_tok_addr, .o_rsp_valid, .o_rsp_code, .i_xact_done, .i_bus_reset, .o_done_flag);
`default_nettype wire
